// file: common/atl_consts.vh
// Constants for the alarm threshold logic: register offsets, field
// positions, reset values and compare scaling.
// Assumes a register port with word offsets and 16-bit data words.
//
// Operation
// - Unlatched alert follows its cause only
// - Latched alert holds until matching read
// - Switch mode overrides interrupt functions and trigger
// - Switch mode drives alert from axis limits
// - Status flags raise alert when enabled
// - Finished conversion set raises alert when enabled
// - Alert after run length plus one crossings
// - Temperature crossings raise alert when enabled
// - Per-axis enables gate X, Y, Z crossings
// - Limits: high bits 15-8, low 7-0, signed
// - Limit scaled by full-scale range over 128
// - Reset limits are 7Dh high, 83h low
// - Axis compare runs only when check enabled
// - Range code 3 behaves as code 0
`ifndef ATL_CONSTS_VH
`define ATL_CONSTS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define ATL_OFS_SETUP 4'h3
`define ATL_OFS_XLIM 4'h4
`define ATL_OFS_YLIM 4'h5

// ************************************************************
// Reset values and write masks
// ************************************************************
`define ATL_SETUP_RST 16'h0000
`define ATL_SETUP_WMASK 16'h393F
`define ATL_LIM_RST 16'h7D83

// ************************************************************
// Field positions of the alarm setup register
// ************************************************************
`define ATL_B_LATCH 13
`define ATL_B_MODE 12
`define ATL_B_FLAG_EN 11
`define ATL_B_DONE_EN 8
`define ATL_B_RUN_HI 5
`define ATL_B_RUN_LO 4
`define ATL_B_TEMP_EN 3
`define ATL_B_Z_EN 2
`define ATL_B_Y_EN 1
`define ATL_B_X_EN 0

// ************************************************************
// Limit fields and range codes
// ************************************************************
`define ATL_HI_MSB 15
`define ATL_HI_LSB 8
`define ATL_LO_MSB 7
`define ATL_LO_LSB 0
`define ATL_RNG_MID 2'h0
`define ATL_RNG_LOW 2'h1
`define ATL_RNG_HIGH 2'h2
// Limit shift for each range, full scale of the widest range = 2^15
`define ATL_SH_MID 7
`define ATL_SH_LOW 6
`define ATL_SH_HIGH 8
// Temperature limit sits on the upper byte of the result
`define ATL_SH_TEMP 8
`define ATL_CH_NUM 4

`endif

// file: rtl/atl_run_counter.v
// Per-channel limit compare with consecutive-crossing run counter.
// Assumes result_vld is a one-cycle pulse per new conversion result
// and limits already scaled to the result's units.
`include "atl_consts.vh"

module atl_run_counter (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Compare inputs
	input wire check_en,
	input wire [1:0] run_len,
	input wire result_vld,
	input wire signed [16:0] result,
	input wire signed [16:0] hi_lim,
	input wire signed [16:0] lo_lim,
	// Channel condition
	output wire hit
);

	reg [1:0] run_r;
	reg [1:0] run_nxt;
	reg hit_r;
	reg hit_nxt;
	wire outside;

	// Strictly above high or below low counts as a crossing
	assign outside = (result > hi_lim) || (result < lo_lim);

	// Counter saturates so a long run keeps the condition present
	always @* begin
		run_nxt = run_r;
		hit_nxt = hit_r;
		if (!check_en) begin
			run_nxt = 2'h0;
			hit_nxt = 1'b0;
		end else if (result_vld) begin
			if (!outside) begin
				run_nxt = 2'h0;
				hit_nxt = 1'b0;
			end else begin
				if (run_r != run_len)
					run_nxt = run_r + 2'h1;
				hit_nxt = (run_r == run_len);
			end
		end
	end

	// Run state
	always @(posedge ref_clk) begin
		if (srst) begin
			run_r <= 2'h0;
			hit_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			hit_r <= hit_nxt;
		end
	end

	assign hit = hit_r;

endmodule

// file: rtl/atl_alarm_latch.v
// Alert source holder: follows its cause, or holds it until cleared.
// Assumes clr is a one-cycle pulse from a register read.
`include "atl_consts.vh"

module atl_alarm_latch (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Source control
	input wire latch_en,
	input wire src,
	input wire clr,
	// Held source
	output wire active
);

	reg held_r;
	reg held_nxt;

	// A cause present in the clearing cycle wins over the clear
	always @* begin
		held_nxt = held_r;
		if (clr)
			held_nxt = 1'b0;
		if (src)
			held_nxt = 1'b1;
		if (!latch_en)
			held_nxt = 1'b0;
	end

	// Sticky state
	always @(posedge ref_clk) begin
		if (srst)
			held_r <= 1'b0;
		else
			held_r <= held_nxt;
	end

	// Unlatched mode shows the live cause
	assign active = latch_en ? (held_r | src) : src;

endmodule

// file: rtl/atl_alarm_top.v
// Alarm threshold logic: setup and X/Y limit registers, per-channel
// limit checks, alert source combination and the alert pin.
// Assumes register accesses, results and flags are synchronous to
// ref_clk; Z and temperature limits, ranges and check enables come
// from neighbouring registers as plain inputs.
`include "atl_consts.vh"

module atl_alarm_top (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Register port
	input wire [3:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	output wire [15:0] reg_rdata,
	output wire reg_hit,
	// Neighbouring configuration
	input wire [15:0] z_field_limits,
	input wire [15:0] t_field_limits,
	input wire [1:0] x_range,
	input wire [1:0] y_range,
	input wire [1:0] z_range,
	input wire x_limit_check_en,
	input wire y_limit_check_en,
	input wire z_limit_check_en,
	// Conversion results
	input wire x_result_vld,
	input wire y_result_vld,
	input wire z_result_vld,
	input wire t_result_vld,
	input wire [15:0] x_result,
	input wire [15:0] y_result,
	input wire [15:0] z_result,
	input wire [15:0] t_result,
	input wire set_done,
	// Status flags and clearing reads
	input wire front_end_flags_any,
	input wire system_flags_any,
	input wire front_end_flags_rd,
	input wire system_flags_rd,
	input wire result_rd,
	// Alert pin and state
	output wire alert_n,
	output wire alert_trig_en,
	output wire [3:0] limit_hits
);

	// ************************************************************
	// Register storage
	// ************************************************************
	reg [15:0] alarm_setup_r;
	reg [15:0] x_field_limits_r;
	reg [15:0] y_field_limits_r;
	reg [15:0] rdata_r;
	reg [15:0] rdata_nxt;
	reg hit_r;
	reg hit_nxt;
	reg alert_n_r;
	reg alert_n_nxt;
	reg done_r;

	wire latch_en;
	wire switch_mode;
	wire flag_alarm_en;
	wire done_alarm_en;
	wire [1:0] crossing_run_len;
	wire temp_limit_alarm_en;
	wire x_limit_alarm_en;
	wire y_limit_alarm_en;
	wire z_limit_alarm_en;

	wire wr_setup;
	wire wr_x;
	wire wr_y;

	// Address decode
	assign wr_setup = reg_wr && (reg_addr == `ATL_OFS_SETUP);
	assign wr_x = reg_wr && (reg_addr == `ATL_OFS_XLIM);
	assign wr_y = reg_wr && (reg_addr == `ATL_OFS_YLIM);

	// Register writes; reserved setup bits never store
	always @(posedge ref_clk) begin
		if (srst) begin
			alarm_setup_r <= `ATL_SETUP_RST;
			x_field_limits_r <= `ATL_LIM_RST;
			y_field_limits_r <= `ATL_LIM_RST;
		end else begin
			if (wr_setup)
				alarm_setup_r <= reg_wdata & `ATL_SETUP_WMASK;
			if (wr_x)
				x_field_limits_r <= reg_wdata;
			if (wr_y)
				y_field_limits_r <= reg_wdata;
		end
	end

	// Read mux, registered so data comes one cycle after the strobe
	always @* begin
		rdata_nxt = rdata_r;
		hit_nxt = 1'b0;
		if (reg_rd) begin
			hit_nxt = 1'b1;
			case (reg_addr)
				`ATL_OFS_SETUP: rdata_nxt = alarm_setup_r;
				`ATL_OFS_XLIM: rdata_nxt = x_field_limits_r;
				`ATL_OFS_YLIM: rdata_nxt = y_field_limits_r;
				default: begin
					rdata_nxt = 16'h0000;
					hit_nxt = 1'b0;
				end
			endcase
		end
	end

	// Read data holds until the next read
	always @(posedge ref_clk) begin
		if (srst) begin
			rdata_r <= 16'h0000;
			hit_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			hit_r <= hit_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_hit = hit_r;

	// ************************************************************
	// Setup fields
	// ************************************************************
	assign latch_en = alarm_setup_r[`ATL_B_LATCH];
	assign switch_mode = alarm_setup_r[`ATL_B_MODE];
	assign flag_alarm_en = alarm_setup_r[`ATL_B_FLAG_EN];
	assign done_alarm_en = alarm_setup_r[`ATL_B_DONE_EN];
	assign crossing_run_len = alarm_setup_r[`ATL_B_RUN_HI:`ATL_B_RUN_LO];
	assign temp_limit_alarm_en = alarm_setup_r[`ATL_B_TEMP_EN];
	assign z_limit_alarm_en = alarm_setup_r[`ATL_B_Z_EN];
	assign y_limit_alarm_en = alarm_setup_r[`ATL_B_Y_EN];
	assign x_limit_alarm_en = alarm_setup_r[`ATL_B_X_EN];

	// Switch mode disables the alert-pin conversion trigger
	assign alert_trig_en = ~switch_mode;

	// ************************************************************
	// Limit scaling
	// ************************************************************
	// Results are taken in units where the widest range spans the
	// full 16-bit code, so narrower ranges shift the limit less.
	function signed [16:0] atl_scale;
		input [7:0] lim;
		input [1:0] rng;
		reg signed [16:0] ext;
		begin
			ext = {{9{lim[7]}}, lim};
			case (rng)
				`ATL_RNG_LOW: atl_scale = ext <<< `ATL_SH_LOW;
				`ATL_RNG_HIGH: atl_scale = ext <<< `ATL_SH_HIGH;
				`ATL_RNG_MID: atl_scale = ext <<< `ATL_SH_MID;
				default: atl_scale = ext <<< `ATL_SH_MID;
			endcase
		end
	endfunction

	// Per-channel vectors: index 0 X, 1 Y, 2 Z, 3 temperature
	wire [15:0] lim_w [0:3];
	wire [1:0] rng_w [0:3];
	wire [15:0] res_w [0:3];
	wire [3:0] vld_w;
	wire [3:0] chk_w;
	wire [3:0] alarm_en_w;
	wire [3:0] hit_w;

	assign lim_w[0] = x_field_limits_r;
	assign lim_w[1] = y_field_limits_r;
	assign lim_w[2] = z_field_limits;
	assign lim_w[3] = t_field_limits;
	assign rng_w[0] = x_range;
	assign rng_w[1] = y_range;
	assign rng_w[2] = z_range;
	assign rng_w[3] = `ATL_RNG_MID;
	assign res_w[0] = x_result;
	assign res_w[1] = y_result;
	assign res_w[2] = z_result;
	assign res_w[3] = t_result;
	assign vld_w = {t_result_vld, z_result_vld, y_result_vld, x_result_vld};
	// Temperature has no check enable of its own; its alarm bit gates it
	assign chk_w = {temp_limit_alarm_en, z_limit_check_en, y_limit_check_en, x_limit_check_en};
	assign alarm_en_w = {temp_limit_alarm_en, z_limit_alarm_en, y_limit_alarm_en, x_limit_alarm_en};

	// ************************************************************
	// Channel compares
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < `ATL_CH_NUM; gi = gi + 1) begin : g_ch
			wire signed [16:0] hi_s;
			wire signed [16:0] lo_s;
			wire signed [16:0] res_s;
			if (gi == 3) begin : g_temp
				// Temperature limit lands on the result's upper byte
				assign hi_s = {{9{lim_w[gi][`ATL_HI_MSB]}}, lim_w[gi][`ATL_HI_MSB:`ATL_HI_LSB]} <<< `ATL_SH_TEMP;
				assign lo_s = {{9{lim_w[gi][`ATL_LO_MSB]}}, lim_w[gi][`ATL_LO_MSB:`ATL_LO_LSB]} <<< `ATL_SH_TEMP;
			end else begin : g_mag
				assign hi_s = atl_scale(lim_w[gi][`ATL_HI_MSB:`ATL_HI_LSB], rng_w[gi]);
				assign lo_s = atl_scale(lim_w[gi][`ATL_LO_MSB:`ATL_LO_LSB], rng_w[gi]);
			end
			assign res_s = {res_w[gi][15], res_w[gi]};
			atl_run_counter u_run (
				.ref_clk(ref_clk),
				.srst(srst),
				.check_en(chk_w[gi]),
				.run_len(crossing_run_len),
				.result_vld(vld_w[gi]),
				.result(res_s),
				.hi_lim(hi_s),
				.lo_lim(lo_s),
				.hit(hit_w[gi])
			);
		end
	endgenerate

	assign limit_hits = hit_w;

	// ************************************************************
	// Alert sources
	// ************************************************************
	wire thr_src;
	wire flag_src;
	wire done_src;
	wire thr_act;
	wire flag_act;
	wire done_act;
	wire sw_src;

	// Conversion set finished: level until the results are read
	always @(posedge ref_clk) begin
		if (srst)
			done_r <= 1'b0;
		else if (set_done)
			done_r <= 1'b1;
		else if (result_rd)
			done_r <= 1'b0;
	end

	// Enabled limit crossings, temperature included
	assign thr_src = |(hit_w & alarm_en_w);
	assign flag_src = flag_alarm_en && (front_end_flags_any || system_flags_any);
	assign done_src = done_alarm_en && (done_r || set_done);

	// Switch output uses magnetic axes only and never latches
	assign sw_src = |(hit_w[2:0] & alarm_en_w[2:0]);

	atl_alarm_latch u_thr (
		.ref_clk(ref_clk),
		.srst(srst),
		.latch_en(latch_en),
		.src(thr_src),
		.clr(result_rd),
		.active(thr_act)
	);

	atl_alarm_latch u_flag (
		.ref_clk(ref_clk),
		.srst(srst),
		.latch_en(latch_en),
		.src(flag_src),
		.clr(front_end_flags_rd | system_flags_rd),
		.active(flag_act)
	);

	atl_alarm_latch u_done (
		.ref_clk(ref_clk),
		.srst(srst),
		.latch_en(latch_en),
		.src(done_src),
		.clr(result_rd),
		.active(done_act)
	);

	// ************************************************************
	// Alert pin
	// ************************************************************
	// Registered so the pin never glitches on decode paths
	always @* begin
		if (switch_mode)
			alert_n_nxt = ~sw_src;
		else
			alert_n_nxt = ~(thr_act | flag_act | done_act);
	end

	always @(posedge ref_clk) begin
		if (srst)
			alert_n_r <= 1'b1;
		else
			alert_n_r <= alert_n_nxt;
	end

	assign alert_n = alert_n_r;

endmodule

// file: bench/atl_alarm_top_properties.sv
// Timing checks on the alarm top module ports.
// Assumes it is bound to atl_alarm_top and sees only its ports.
// ************************************************************
// Checker
// ************************************************************
module atl_alarm_top_properties (
	// Clock and reset
	input logic ref_clk,
	input logic srst,
	// Register port
	input logic [3:0] reg_addr,
	input logic reg_wr,
	input logic reg_rd,
	input logic [15:0] reg_wdata,
	input logic [15:0] reg_rdata,
	// Limit channel
	input logic x_limit_check_en,
	input logic x_result_vld,
	input logic [3:0] limit_hits,
	// Alert causes and pin
	input logic set_done,
	input logic front_end_flags_any,
	input logic front_end_flags_rd,
	input logic system_flags_rd,
	input logic result_rd,
	input logic alert_n,
	input logic alert_trig_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cfg_r;
	wire mode_w = cfg_r[12];
	wire lat_w = cfg_r[13];
	wire clr_w = result_rd | front_end_flags_rd | system_flags_rd;
	wire [2:0] sw_w = limit_hits[2:0] & cfg_r[2:0];
	wire quiet_w = !mode_w && !lat_w && !cfg_r[11] && !cfg_r[8] && ((limit_hits & cfg_r[3:0]) == 4'h0);
	// Setup mirror, updated on the same edge as the design register
	always_ff @(posedge ref_clk) begin
		if (srst)
			cfg_r <= 16'h0000;
		else if (reg_wr && reg_addr == 4'h3)
			cfg_r <= reg_wdata;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Three quiet cycles, so a latch change cannot leave stale sticky state
	sequence s_held;
		lat_w && !mode_w && !clr_w && !reg_wr;
	endsequence
	sequence s_done;
		!mode_w && cfg_r[8] && set_done;
	endsequence
	property p_trig;
		reg_wr && reg_addr == 4'h3 |=> alert_trig_en == !$past(reg_wdata[12]);
	endproperty
	property p_rsv;
		reg_rd && reg_addr == 4'h3 |=> (reg_rdata & 16'hC6C0) == 16'h0000;
	endproperty
	property p_chk_off;
		!x_limit_check_en |=> !limit_hits[0];
	endproperty
	property p_hit_vld;
		$rose(limit_hits[0]) |-> $past(x_result_vld);
	endproperty
	property p_switch;
		mode_w && $past(mode_w) |-> alert_n == !(|$past(sw_w));
	endproperty
	property p_unlatch;
		$past(quiet_w) |-> alert_n;
	endproperty
	property p_flag;
		!mode_w && !lat_w && cfg_r[11] && front_end_flags_any |=> !alert_n;
	endproperty
	property p_done;
		s_done |=> !alert_n;
	endproperty
	property p_hold;
		s_held ##1 s_held ##1 (s_held and !alert_n) |=> !alert_n;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger enable wrong");
	a_rsv: assert property (p_rsv) else $error("reserved setup bit set");
	a_chk_off: assert property (p_chk_off) else $error("hit with check off");
	a_hit_vld: assert property (p_hit_vld) else $error("hit without result");
	a_switch: assert property (p_switch) else $error("switch pin wrong");
	a_unlatch: assert property (p_unlatch) else $error("alert without cause");
	a_flag: assert property (p_flag) else $error("flag alert missing");
	a_done: assert property (p_done) else $error("done alert missing");
	a_hold: assert property (p_hold) else $error("latched alert dropped");
endmodule

bind atl_alarm_top atl_alarm_top_properties u_props (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .x_limit_check_en, .x_result_vld, .limit_hits, .set_done,
	.front_end_flags_any, .front_end_flags_rd, .system_flags_rd, .result_rd, .alert_n, .alert_trig_en);

// file: bench/atl_host_model.sv
// Host model: clearing register reads and per-axis compare enables.
// Assumes bench requests change by non-blocking assignment at the falling edge.
// ************************************************************
// Host
// ************************************************************
module atl_host_model (
	// Clock
	input logic ref_clk,
	// Bench requests
	input logic [2:0] rd_req,
	input logic [2:0] chk_req,
	// Toward the block
	output logic front_end_flags_rd = 1'b0,
	output logic system_flags_rd = 1'b0,
	output logic result_rd = 1'b0,
	output logic [2:0] check_en = 3'h7
);
	timeunit 1ns;
	timeprecision 1ps;
	// Moved off the sampling edge; one falling edge behind the request
	always @(negedge ref_clk) begin
		{front_end_flags_rd, system_flags_rd, result_rd} <= rd_req;
		check_en <= chk_req;
	end
endmodule

// file: bench/alarm_threshold_logic_tb.sv
// Bench for the alarm top: register tasks, result pulses, alert checks.
// Assumes the design, its header and the host model are compiled first.
// ************************************************************
// Bench
// ************************************************************
module alarm_threshold_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [1:0] xr = 2'h0;
	logic [3:0] vld = 4'h0;
	logic [3:0][15:0] res = '0;
	logic set_done = 1'b0;
	logic fe_any = 1'b0;
	logic sy_any = 1'b0;
	logic [2:0] rd_req = 3'h0;
	logic [2:0] chk_req = 3'h7;
	logic [15:0] lim;
	int sh[4] = '{7, 6, 8, 7};
	wire [2:0] chk_en;
	wire fe_rd, sy_rd, r_rd, reg_hit, alert_n, alert_trig_en;
	wire [15:0] reg_rdata;
	wire [3:0] limit_hits;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	always #20 ref_clk = ~ref_clk;
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			complete_run();
		end
	end
	atl_host_model u_host (.ref_clk(ref_clk), .rd_req(rd_req), .chk_req(chk_req),
		.front_end_flags_rd(fe_rd), .system_flags_rd(sy_rd), .result_rd(r_rd), .check_en(chk_en));
	atl_alarm_top uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.z_field_limits(16'h7D83), .t_field_limits(16'h0AF6), .x_range(xr), .y_range(2'h0),
		.z_range(2'h0), .x_limit_check_en(chk_en[0]), .y_limit_check_en(chk_en[1]),
		.z_limit_check_en(chk_en[2]), .x_result_vld(vld[0]), .y_result_vld(vld[1]),
		.z_result_vld(vld[2]), .t_result_vld(vld[3]), .x_result(res[0]), .y_result(res[1]),
		.z_result(res[2]), .t_result(res[3]), .set_done(set_done), .front_end_flags_any(fe_any),
		.system_flags_any(sy_any), .front_end_flags_rd(fe_rd), .system_flags_rd(sy_rd),
		.result_rd(r_rd), .alert_n(alert_n), .alert_trig_en(alert_trig_en), .limit_hits(limit_hits));
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic step;
		@(negedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		step;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic hit);
		step;
		reg_addr = a;
		reg_rd = 1'b1;
		step;
		reg_rd = 1'b0;
		chk(reg_rdata, exp);
		chk1(reg_hit, hit);
	endtask
	task automatic send(input int ch, input logic [15:0] v);
		step;
		res[ch] = v;
		vld[ch] = 1'b1;
		step;
		vld[ch] = 1'b0;
	endtask
	// Host clearing read {front end, system, result}, then two edges to settle
	task automatic clr(input logic [2:0] m);
		rd_req <= m;
		step;
		rd_req <= 3'h0;
		repeat (2) step;
	endtask
	initial begin
		repeat (2) step;
		srst = 1'b0;
		rd(4'h3, 16'h0000, 1'b1);
		rd(4'h4, 16'h7D83, 1'b1);
		rd(4'h5, 16'h7D83, 1'b1);
		rd(4'h0, 16'h0000, 1'b0);
		chk1(alert_trig_en, 1'b1);
		wr(4'h3, 16'hFFFF);
		wr(4'h0, 16'h1234);
		rd(4'h3, 16'h393F, 1'b1);
		chk1(alert_trig_en, 1'b0);
		wr(4'h5, 16'hA55A);
		rd(4'h5, 16'hA55A, 1'b1);
		wr(4'h5, 16'h7D83);
		$display("registers done");
		// Each run length, with one inside result breaking an earlier run
		for (int n = 0; n < 4; n++) begin
			wr(4'h3, {10'h000, n[1:0], 4'h1});
			repeat (n) send(0, 16'h7FFF);
			send(0, 16'h0000);
			repeat (n) send(0, 16'h7FFF);
			chk1(limit_hits[0], 1'b0);
			send(0, 16'h8000);
			chk1(limit_hits[0], 1'b1);
			step;
			chk1(alert_n, 1'b0);
			send(0, 16'h0000);
			chk1(limit_hits[0], 1'b0);
			step;
			chk1(alert_n, 1'b1);
		end
		$display("run length done");
		// Limits of +1/-1 scaled by every range code, edges both sides
		wr(4'h3, 16'h0001);
		wr(4'h4, 16'h01FF);
		for (int c = 0; c < 4; c++) begin
			xr = c[1:0];
			lim = 16'h0001 << sh[c];
			send(0, lim);
			chk1(limit_hits[0], 1'b0);
			send(0, lim + 16'h0001);
			chk1(limit_hits[0], 1'b1);
			send(0, -lim);
			chk1(limit_hits[0], 1'b0);
			send(0, ~lim);
			chk1(limit_hits[0], 1'b1);
		end
		chk_req <= 3'h6;
		send(0, 16'h7FFF);
		chk1(limit_hits[0], 1'b0);
		chk_req <= 3'h7;
		send(1, 16'h7FFF);
		chk1(limit_hits[1], 1'b1);
		step;
		chk1(alert_n, 1'b1);
		wr(4'h3, 16'h0002);
		step;
		chk1(alert_n, 1'b0);
		send(1, 16'h0000);
		wr(4'h3, 16'h0008);
		send(3, 16'h0B00);
		chk1(limit_hits[3], 1'b1);
		step;
		chk1(alert_n, 1'b0);
		wr(4'h3, 16'h0000);
		send(3, 16'h0B00);
		chk1(limit_hits[3], 1'b0);
		chk1(alert_n, 1'b1);
		$display("limits done");
		// Both flag sources, unlatched and latched
		for (int k = 0; k < 4; k++) begin
			wr(4'h3, {2'h0, k[0], 13'h0800});
			{fe_any, sy_any} = k[1] ? 2'b01 : 2'b10;
			repeat (2) step;
			chk1(alert_n, 1'b0);
			{fe_any, sy_any} = 2'b00;
			repeat (3) step;
			chk1(alert_n, !k[0]);
			clr(k[1] ? 3'h2 : 3'h4);
			chk1(alert_n, 1'b1);
		end
		wr(4'h3, 16'h0000);
		fe_any = 1'b1;
		repeat (2) step;
		chk1(alert_n, 1'b1);
		fe_any = 1'b0;
		for (int d = 0; d < 2; d++) begin
			wr(4'h3, {7'h00, d[0], 8'h00});
			set_done = 1'b1;
			step;
			set_done = 1'b0;
			step;
			chk1(alert_n, !d[0]);
			clr(3'h1);
			chk1(alert_n, 1'b1);
		end
		$display("flags done");
		// Switch mode ignores flags and follows the X limit check
		wr(4'h3, 16'h1801);
		chk1(alert_trig_en, 1'b0);
		fe_any = 1'b1;
		repeat (2) step;
		chk1(alert_n, 1'b1);
		send(0, 16'h7FFF);
		step;
		chk1(alert_n, 1'b0);
		send(0, 16'h0000);
		step;
		chk1(alert_n, 1'b1);
		fe_any = 1'b0;
		$display("switch done");
		// Mid-run reset must bring back the limit and setup reset values
		srst = 1'b1;
		repeat (2) step;
		srst = 1'b0;
		rd(4'h4, 16'h7D83, 1'b1);
		chk1(alert_trig_en, 1'b1);
		$display("reset done");
		complete_run();
	end
endmodule
